/* File: fis_pkg.sv */
// Behaviour
// - Each received data byte is committed to the array as soon as its eighth bit lands, with no busy state.
// - The array holds 65,536 locations of 8 bits, all reachable over the serial link.
// - The device answers only when the three select bits of the slave address equal the select pin levels.
// - A select pin left open reads as zero thanks to an internal pull-down; the code models no pull-down, so an open pin does not read zero.
// - Serial bits are sampled on the rising clock edge and outgoing bits change after the falling edge.
// - The data line is only pulled low or released, never driven high.
// - With write protect high no location is modified; with it low all locations take writes.
// - Write protect left open reads low, so writes are enabled; the code models no pull-down on wp, so an open pin does not read low.
// - The device works with serial clock rates up to 3.4 MHz in high-speed mode.
// - The device also works with the 100 kHz and 400 kHz bus timings.
// - A read-only identification value tells maker, density and revision.
// - The sleep command puts the device to sleep whether or not a STOP follows.
// - The slave address byte is 1010b, three select bits and a direction bit (1 read, 0 write).
// - On a write the two bytes after the slave address are latched as the 16-bit current address.
// - The address increments after every byte and wraps from ffff to 0000 with no burst limit.
// - Master code 00001xxx enters high-speed mode, which lasts until a STOP.
package fis_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam logic [3:0] SLAVE_ID = 4'ha;
  localparam logic [4:0] MASTER_CODE = 5'h01;
  localparam logic [6:0] RSV_ADDR = 7'h7c;
  localparam logic [7:0] SLEEP_CMD = 8'h86;
  localparam logic [23:0] ID_DEFAULT = 24'h05a3c1; // Arbitrary identification value
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [1:0] ID_LAST = 2'h2;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned HS_THIGH_NS = 60;
  localparam int unsigned HS_THIGH_CYC = (HS_THIGH_NS * CLK_MHZ) / 1000;
  localparam int unsigned SYNC_CYC = 3;
  // Protocol states, Gray coded along slave, address, data
  typedef enum logic [2:0] {
    FIS_IDLE = 3'h0,
    FIS_SLV = 3'h1,
    FIS_AHI = 3'h3,
    FIS_ALO = 3'h2,
    FIS_WR = 3'h6,
    FIS_RD = 3'h7,
    FIS_IGN = 3'h5,
    FIS_IDB = 3'h4
  } fis_state_e;
  // Pin and link levels carried into the core clock domain
  typedef struct packed {
    logic scl;
    logic sda;
    logic tog;
    logic wp;
    logic [2:0] sel;
  } fis_pins_s;
endpackage

/* File: fis_sync.sv */
`timescale 1ns/10ps
module fis_sync import fis_pkg::*; #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  if (WIDTH < 1) begin : g_chk
    $error("fis_sync needs at least one bit");
  end

  // Two flops; the first is read only by the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // fis_sync

/* File: fis_mem.sv */
`timescale 1ns/10ps
module fis_mem import fis_pkg::*; #(
  parameter int unsigned MEM_DW = DATA_W,
  parameter int unsigned MEM_AW = ADDR_W
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [MEM_AW-1:0] waddr,
  input wire logic [MEM_DW-1:0] wdata,
  input wire logic [MEM_AW-1:0] raddr,
  output logic [MEM_DW-1:0] rdata
);
  logic [MEM_DW-1:0] mem_array [0:(1 << MEM_AW)-1];

  if (MEM_AW < 1 || MEM_AW > 24 || MEM_DW < 1) begin : g_chk
    $error("fis_mem size out of range");
  end

  // Write commits on the edge it is requested; read data registered
  always_ff @(posedge clk) begin
    if (we) begin
      mem_array[waddr] <= wdata;
    end
    rdata <= mem_array[raddr];
  end
endmodule // fis_mem

/* File: fis_i2c_slave.sv */
`timescale 1ns/10ps
module fis_i2c_slave import fis_pkg::*; #(
  parameter logic [23:0] ID_VALUE = ID_DEFAULT // Arbitrary identification value
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic wp,
  input wire logic [2:0] device_select_pins,
  output logic hs_mode,
  output logic asleep
);
  logic lk_bit_reg;
  logic lk_tog_reg;
  fis_pins_s pins_raw;
  fis_pins_s pins_s;
  logic scl_d_reg;
  logic sda_d_reg;
  logic tog_d_reg;
  logic bit_ev;
  logic fall_ev;
  logic start_ev;
  logic stop_ev;
  fis_state_e state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shreg_reg;
  logic [7:0] tx_reg;
  logic [15:0] addr_reg;
  logic ack_pend_reg;
  logic id_armed_reg;
  logic id_mode_reg;
  logic [1:0] id_idx_reg;
  logic [7:0] id_byte;
  logic [7:0] byte_v;
  logic byte_done;
  logic dev_hit;
  logic mc_hit;
  logic rsv_hit;
  logic wr_en_reg;
  logic [15:0] wr_addr_reg;
  logic [7:0] wr_data_reg;
  logic [7:0] rd_data;
  logic sda_oe_reg;
  logic hs_mode_reg;
  logic asleep_reg;

  // Oversampling margin must fit the shortest high phase; slower rates have longer ones
  if (HS_THIGH_CYC <= SYNC_CYC) begin : g_chk
    $error("core clock too slow for high-speed serial clock");
  end

  // Link side: sample data on each rising serial clock and flag it by toggle
  always_ff @(posedge scl or negedge rst_n) begin
    if (!rst_n) begin
      lk_bit_reg <= 1'b0;
      lk_tog_reg <= 1'b0;
    end else begin
      lk_bit_reg <= sda_i;
      lk_tog_reg <= ~lk_tog_reg;
    end
  end

  // Pins and link toggle cross into the core domain; no pull-down is modelled, so open pins are not read low
  assign pins_raw = '{scl: scl, sda: sda_i, tog: lk_tog_reg, wp: wp, sel: device_select_pins};

  fis_sync #(
    .WIDTH($bits(fis_pins_s))
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(pins_raw),
    .q(pins_s)
  );

  // Delayed copies for edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d_reg <= 1'b0;
      sda_d_reg <= 1'b0;
      tog_d_reg <= 1'b0;
    end else begin
      scl_d_reg <= pins_s.scl;
      sda_d_reg <= pins_s.sda;
      tog_d_reg <= pins_s.tog;
    end
  end

  // Bus events; the link bit is stable while its toggle is seen
  assign bit_ev = pins_s.tog ^ tog_d_reg;
  assign fall_ev = scl_d_reg && !pins_s.scl;
  assign start_ev = scl_d_reg && pins_s.scl && sda_d_reg && !pins_s.sda;
  assign stop_ev = scl_d_reg && pins_s.scl && !sda_d_reg && pins_s.sda;

  // Byte decode
  assign byte_v = {shreg_reg[6:0], lk_bit_reg};
  assign byte_done = bit_ev && bit_cnt_reg == LAST_BIT;
  assign dev_hit = byte_v[7:4] == SLAVE_ID && byte_v[3:1] == pins_s.sel;
  assign mc_hit = byte_v[7:3] == MASTER_CODE;
  assign rsv_hit = byte_v[7:1] == RSV_ADDR;

  // Identification bytes, most significant first
  always_comb begin
    case (id_idx_reg)
      2'h0: id_byte = ID_VALUE[23:16];
      2'h1: id_byte = ID_VALUE[15:8];
      default: id_byte = ID_VALUE[7:0];
    endcase
  end

  // Protocol engine: framing, bit count, address and transmit data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= FIS_IDLE;
      bit_cnt_reg <= 4'h0;
      shreg_reg <= 8'h00;
      tx_reg <= 8'hff;
      addr_reg <= 16'h0000;
      ack_pend_reg <= 1'b0;
      id_armed_reg <= 1'b0;
      id_mode_reg <= 1'b0;
      id_idx_reg <= 2'h0;
    end else if (stop_ev) begin
      state_reg <= FIS_IDLE;
      bit_cnt_reg <= 4'h0;
      ack_pend_reg <= 1'b0;
      id_armed_reg <= 1'b0;
      id_mode_reg <= 1'b0;
    end else if (start_ev) begin
      state_reg <= FIS_SLV;
      bit_cnt_reg <= 4'h0;
      ack_pend_reg <= 1'b0;
      id_mode_reg <= 1'b0;
    end else if (bit_ev && state_reg != FIS_IDLE) begin
      if (bit_cnt_reg == ACK_BIT) begin
        bit_cnt_reg <= 4'h0;
        ack_pend_reg <= 1'b0;
        if (state_reg == FIS_RD && !ack_pend_reg) begin
          if (lk_bit_reg) begin
            state_reg <= FIS_IGN; // Master NACK ends the read
          end else if (id_mode_reg) begin
            tx_reg <= id_byte;
            id_idx_reg <= (id_idx_reg == ID_LAST) ? 2'h0 : id_idx_reg + 2'h1;
          end else begin
            tx_reg <= rd_data;
          end
        end
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        shreg_reg <= byte_v;
        tx_reg <= {tx_reg[6:0], 1'b1};
        if (bit_cnt_reg == LAST_BIT) begin
          case (state_reg)
            FIS_SLV: begin
              ack_pend_reg <= 1'b0;
              id_armed_reg <= 1'b0;
              state_reg <= FIS_IGN;
              if (mc_hit) begin
                ack_pend_reg <= 1'b0; // Master code is never acknowledged
              end else if (dev_hit && !asleep_reg) begin
                ack_pend_reg <= 1'b1;
                if (byte_v[0]) begin
                  state_reg <= FIS_RD;
                  tx_reg <= rd_data;
                end else begin
                  state_reg <= FIS_AHI;
                end
              end else if (rsv_hit && !byte_v[0]) begin
                ack_pend_reg <= 1'b1;
                state_reg <= FIS_IDB;
              end else if (rsv_hit && id_armed_reg) begin
                ack_pend_reg <= 1'b1;
                state_reg <= FIS_RD;
                id_mode_reg <= 1'b1;
                id_idx_reg <= 2'h1;
                tx_reg <= ID_VALUE[23:16];
              end else if (byte_v == SLEEP_CMD && id_armed_reg) begin
                ack_pend_reg <= 1'b1;
              end
            end
            FIS_IDB: begin
              state_reg <= FIS_IGN;
              if (dev_hit) begin
                ack_pend_reg <= 1'b1;
                id_armed_reg <= 1'b1;
              end
            end
            FIS_AHI: begin
              addr_reg[15:8] <= byte_v;
              ack_pend_reg <= 1'b1;
              state_reg <= FIS_ALO;
            end
            FIS_ALO: begin
              addr_reg[7:0] <= byte_v;
              ack_pend_reg <= 1'b1;
              state_reg <= FIS_WR;
            end
            FIS_WR: begin
              addr_reg <= addr_reg + 16'h0001;
              ack_pend_reg <= 1'b1;
            end
            FIS_RD: begin
              ack_pend_reg <= 1'b0;
              if (!id_mode_reg) begin
                addr_reg <= addr_reg + 16'h0001;
              end
            end
            default: ack_pend_reg <= 1'b0;
          endcase
        end
      end
    end
  end

  // Commit a written byte the cycle after its last bit; protect blocks it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_en_reg <= 1'b0;
      wr_addr_reg <= 16'h0000;
      wr_data_reg <= 8'h00;
    end else begin
      wr_en_reg <= byte_done && state_reg == FIS_WR && !pins_s.wp;
      wr_addr_reg <= addr_reg;
      wr_data_reg <= byte_v;
    end
  end

  fis_mem #(
    .MEM_DW(DATA_W),
    .MEM_AW(ADDR_W)
  ) u_mem (
    .clk(clk),
    .we(wr_en_reg),
    .waddr(wr_addr_reg),
    .wdata(wr_data_reg),
    .raddr(addr_reg),
    .rdata(rd_data)
  );

  // Data line drive, set only after a falling serial clock; start and stop release it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_oe_reg <= 1'b0;
    end else if (start_ev || stop_ev) begin
      sda_oe_reg <= 1'b0;
    end else if (fall_ev) begin
      if (bit_cnt_reg == ACK_BIT) begin
        sda_oe_reg <= ack_pend_reg;
      end else if (state_reg == FIS_RD) begin
        sda_oe_reg <= !tx_reg[7];
      end else begin
        sda_oe_reg <= 1'b0;
      end
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe = sda_oe_reg;

  // High-speed mode flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hs_mode_reg <= 1'b0;
    end else if (stop_ev) begin
      hs_mode_reg <= 1'b0;
    end else if (byte_done && state_reg == FIS_SLV && mc_hit) begin
      hs_mode_reg <= 1'b1;
    end
  end

  assign hs_mode = hs_mode_reg;

  // Sleep entry needs no STOP; a matching slave address wakes the device
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      asleep_reg <= 1'b0;
    end else if (byte_done && state_reg == FIS_SLV) begin
      if (byte_v == SLEEP_CMD && id_armed_reg) begin
        asleep_reg <= 1'b1;
      end else if (dev_hit) begin
        asleep_reg <= 1'b0;
      end
    end
  end

  assign asleep = asleep_reg;

  // Checks on the core domain
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_slv_byte;
    byte_done && state_reg == FIS_SLV;
  endsequence
  sequence s_wr_byte;
    byte_done && state_reg == FIS_WR;
  endsequence
  sequence s_alo_byte;
    byte_done && state_reg == FIS_ALO;
  endsequence

  a_start_frame: assert property (start_ev && !stop_ev |=> state_reg == FIS_SLV && bit_cnt_reg == 4'h0)
    else $error("start did not reframe");
  a_dev_ack: assert property (s_slv_byte ##0 (dev_hit && !asleep_reg && !mc_hit) |=> ack_pend_reg)
    else $error("matching address not acknowledged");
  a_miss_quiet: assert property (state_reg == FIS_IGN && !ack_pend_reg && fall_ev |=> !sda_oe_reg)
    else $error("line driven while ignoring");
  a_write_commit: assert property (s_wr_byte ##0 !pins_s.wp |=> wr_en_reg && wr_data_reg == $past(byte_v))
    else $error("written byte not committed");
  a_wp_blocks: assert property (wr_en_reg |-> !$past(pins_s.wp))
    else $error("write while protected");
  a_addr_incr: assert property (s_wr_byte |=> addr_reg == $past(addr_reg) + 16'h0001)
    else $error("address not incremented");
  a_addr_latch: assert property (s_alo_byte |=> addr_reg[7:0] == $past(byte_v) ##1 state_reg == FIS_WR)
    else $error("low address not latched");
  a_fall_drive: assert property ($rose(sda_oe_reg) |-> $past(fall_ev))
    else $error("line pulled low off a falling edge");
  a_hs_enter: assert property (s_slv_byte ##0 mc_hit |=> hs_mode_reg && !ack_pend_reg)
    else $error("master code not taken");
  a_hs_stop: assert property (stop_ev |=> !hs_mode_reg)
    else $error("high-speed mode survived stop");
  a_sleep_enter: assert property (s_slv_byte ##0 (byte_v == SLEEP_CMD && id_armed_reg) |=> asleep_reg [*2])
    else $error("sleep command not taken");
endmodule // fis_i2c_slave

/* File: fis_i2c_master_model.sv */
`timescale 1ns/10ps
// Bus master: makes the serial clock and pulls the data line low through an open drain
module fis_i2c_master_model (
  output logic scl,
  output logic sda_oe,
  input wire logic sda
);
  localparam realtime QTR = 40.0; // Quarter of the 160 ns serial clock period
  // Clock parks high and data is released outside frames
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // One bit: data moves while the clock is low, the line is sampled mid-high
  task automatic xfer_bit(input logic b, output logic got);
    sda_oe = ~b;
    #(QTR) scl = 1'b1;
    #(QTR) got = sda;
    #(QTR) scl = 1'b0;
    #(QTR);
  endtask
  // Start or repeated start; the small offset keeps edges off the core clock grid
  task automatic start_cond();
    #1.7 sda_oe = 1'b0;
    #(QTR) scl = 1'b1;
    #(QTR) sda_oe = 1'b1;
    #(QTR) scl = 1'b0;
    #(QTR);
  endtask
  // Stop: data rises while the clock is high
  task automatic stop_cond();
    sda_oe = 1'b1;
    #(QTR) scl = 1'b1;
    #(QTR) sda_oe = 1'b0;
    #(QTR);
  endtask
  // Byte out, most significant bit first, then the receiver's acknowledge
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic unused;
    logic got;
    for (int i = 7; i >= 0; i--) xfer_bit(d[i], unused);
    xfer_bit(1'b1, got);
    ack = ~got;
  endtask
  // Byte in, then the master's acknowledge or not
  task automatic recv_byte(input logic ack, output logic [7:0] d);
    logic unused;
    for (int i = 7; i >= 0; i--) xfer_bit(1'b1, d[i]);
    xfer_bit(~ack, unused);
  endtask
endmodule // fis_i2c_master_model

/* File: fis_i2c_slave_tb_top.sv */
`timescale 1ns/10ps
module fis_i2c_slave_tb_top import fis_pkg::*;;
  logic clk, rst_n, wp, scl, m_oe, sda_o, sda_oe, hs_mode, asleep;
  logic [2:0] sel_pins;
  wire logic sda_w;
  int error_cnt = 0;
  int total_checks = 0;
  logic [7:0] exp_mem [logic [15:0]];
  // Pulled-up wire, low when any party pulls
  assign sda_w = ~(m_oe | sda_oe);
  fis_i2c_slave dut (.clk(clk), .rst_n(rst_n), .scl(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
    .wp(wp), .device_select_pins(sel_pins), .hs_mode(hs_mode), .asleep(asleep));
  fis_i2c_master_model m (.scl(scl), .sda_oe(m_oe), .sda(sda_w));
  // Core clock, 5 ns
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Expected acknowledge of a slave address that carries select code s
  function automatic logic exp_sel_ack(input logic [2:0] s);
    return s === sel_pins;
  endfunction
  // Address of the i-th byte of a burst; wraps past the top address
  function automatic logic [15:0] burst_addr(input logic [15:0] a, input int i);
    return a + 16'(i);
  endfunction
  // Start, write slave address and the two memory address bytes
  task automatic addr_phase(input logic [15:0] a);
    logic ack;
    m.start_cond();
    m.send_byte({SLAVE_ID, sel_pins, 1'b0}, ack);
    chk(ack, 1'b1);
    m.send_byte(a[15:8], ack);
    m.send_byte(a[7:0], ack);
    chk(ack, 1'b1);
  endtask
  task automatic write_burst(input logic [15:0] a, input int n);
    logic ack;
    logic [7:0] d;
    logic [15:0] k;
    addr_phase(a);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      k = burst_addr(a, i);
      m.send_byte(d, ack);
      chk(ack, 1'b1);
      if (wp === 1'b0) exp_mem[k] = d;
    end
    m.stop_cond();
  endtask
  task automatic read_check(input logic [15:0] a, input int n);
    logic ack;
    logic [7:0] d;
    logic [15:0] k;
    addr_phase(a);
    m.start_cond();
    m.send_byte({SLAVE_ID, sel_pins, 1'b1}, ack);
    chk(ack, 1'b1);
    for (int i = 0; i < n; i++) begin
      k = burst_addr(a, i);
      m.recv_byte(i < n - 1, d);
      chk(d, exp_mem[k]);
    end
    m.stop_cond();
  endtask
  // Reserved address, own select address, repeated start
  task automatic id_prefix();
    logic ack;
    m.start_cond();
    m.send_byte({RSV_ADDR, 1'b0}, ack);
    chk(ack, 1'b1);
    m.send_byte({SLAVE_ID, sel_pins, 1'b0}, ack);
    chk(ack, 1'b1);
    m.start_cond();
  endtask
  // Watchdog, well beyond the expected run of about 125 us
  initial begin
    #400000;
    error_cnt++;
    final_report();
  end
  initial begin
    logic ack;
    logic [7:0] d;
    logic [23:0] id;
    logic [15:0] a;
    void'($urandom(32'h13a80552));
    rst_n = 1'b0;
    wp = 1'b0;
    sel_pins = 3'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    sel_pins <= 3'($urandom);
    repeat (6) @(posedge clk);
    chk({sda_oe, hs_mode, asleep}, 3'h0);
    // Back-to-back write and read, then a burst across the top address
    a = 16'($urandom);
    write_burst(a, 6);
    read_check(a, 6);
    write_burst(16'hfffe, 4);
    read_check(16'hfffe, 4);
    $display("test burst done");
    // Protected writes are acknowledged but leave the array alone
    @(posedge clk) wp <= 1'b1;
    repeat (4) @(posedge clk);
    write_burst(a, 3);
    @(posedge clk) wp <= 1'b0;
    repeat (4) @(posedge clk);
    read_check(a, 3);
    $display("test protect done");
    // Every select code against the strap
    for (int s = 0; s < 8; s++) begin
      m.start_cond();
      m.send_byte({SLAVE_ID, 3'(s), 1'b0}, ack);
      chk(ack, exp_sel_ack(3'(s)));
      m.send_byte(8'h00, ack);
      chk(ack, exp_sel_ack(3'(s)));
      m.stop_cond();
      @(posedge clk);
    end
    @(posedge clk) sel_pins <= 3'h0;
    repeat (4) @(posedge clk);
    $display("test select done");
    // High-speed entry lasts across a repeated start until stop
    m.start_cond();
    m.send_byte({MASTER_CODE, 3'($urandom)}, ack);
    chk(ack, 1'b0);
    repeat (8) @(posedge clk);
    chk(hs_mode, 1'b1);
    addr_phase(16'($urandom));
    chk(hs_mode, 1'b1);
    m.stop_cond();
    repeat (8) @(posedge clk);
    chk(hs_mode, 1'b0);
    $display("test high speed done");
    // Sleep without stop, then a refused address wakes the device
    id_prefix();
    m.send_byte(SLEEP_CMD, ack);
    chk(ack, 1'b1);
    repeat (8) @(posedge clk);
    chk(asleep, 1'b1);
    m.start_cond();
    m.send_byte({SLAVE_ID, sel_pins, 1'b0}, ack);
    chk(ack, 1'b0);
    m.stop_cond();
    chk(asleep, 1'b0);
    // Sleep followed by a stop holds as well, and a read address wakes it
    id_prefix();
    m.send_byte(SLEEP_CMD, ack);
    chk(ack, 1'b1);
    m.stop_cond();
    chk(asleep, 1'b1);
    m.start_cond();
    m.send_byte({SLAVE_ID, sel_pins, 1'b1}, ack);
    chk(ack, 1'b0);
    m.stop_cond();
    chk(asleep, 1'b0);
    $display("test sleep done");
    // Identification bytes come out and then repeat
    id_prefix();
    m.send_byte({RSV_ADDR, 1'b1}, ack);
    chk(ack, 1'b1);
    id = 24'h0;
    for (int i = 0; i < 4; i++) begin
      m.recv_byte(i < 3, d);
      if (i < 3) id = {id[15:0], d};
    end
    m.stop_cond();
    chk(id, ID_DEFAULT);
    chk(d, ID_DEFAULT[23:16]);
    chk(sda_o, 1'b0);
    $display("test ident done");
    final_report();
  end
endmodule // fis_i2c_slave_tb_top
